/* File: logic/frb_pkg.sv */
// Constants for the flash read-path block: register map, fields, timing
package frb_pkg;
	// Register byte offsets
	localparam logic [7:0] CFG_OFS = 8'h00;
	localparam logic [7:0] MODE_OFS = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam logic [7:0] PROG_OFS = 8'h0C;
	// Configuration field positions
	localparam int READ_SELECT_POS = 15;
	localparam int LATENCY_LSB = 11;
	localparam int WAIT_POLARITY_POS = 10;
	localparam int DATA_HOLD_POS = 9;
	localparam int WAIT_TIMING_POS = 8;
	localparam int ACTIVE_EDGE_POS = 6;
	localparam int WRAP_SELECT_POS = 3;
	localparam int LENGTH_LSB = 0;
	localparam logic [15:0] CFG_RESET = 16'hBFCF;
	// Latency and length codes
	localparam logic [2:0] LAT_2 = 3'h2;
	localparam logic [2:0] LAT_5 = 3'h5;
	localparam logic [2:0] LEN_4 = 3'h1;
	localparam logic [2:0] LEN_8 = 3'h2;
	localparam logic [2:0] LEN_16 = 3'h3;
	localparam logic [2:0] LEN_CONT = 3'h7;
	// Automatic standby after bus inactivity, then AXI response codes
	localparam int CLK_MHZ = 20;
	localparam int STANDBY_NS = 150;
	localparam int STANDBY_CYC = (STANDBY_NS * CLK_MHZ + 999) / 1000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Read source selected by the last read command
	typedef enum logic [1:0] {
		frb_src_array,
		frb_src_status,
		frb_src_query,
		frb_src_sig
	} frb_src_t;
endpackage

/* File: logic/frb_read_path.sv */
// Flash read path: async page reads, sync bursts, wait flag, AXI4-Lite cfg
// Notes on behaviour
// - Async reads only while read-select bit set
// - Async data source follows last read command
// - Four-word page; first access long, rest short
// - Standby after 150ns idle, outputs stay driven
// - Wait flag deasserted in async mode
// - Burst starts at active edge after enables
// - Address self-increments after latency delay
// - Length 4, 8, 16 or continuous
// - Each word held one or two clocks
// - Wrap keeps burst in aligned block
// - Misaligned no-wrap start waits at boundary
// - Continuous bursts ignore the wrap bit
// - Wait during latency, waits and after end
// - Wait polarity follows configuration bit
// - Suspend keeps sensing and latched data
// - Resume continues from exact halted state
// - Suspend allowed in latency or output
// - Wait released when either enable high
// - Single synchronous read repeats one word
// - Non-array reads drive wait like bursts
// - One bank busy; other banks read freely
// - Latency codes 2 to 5 cycles
// - Length codes 001, 010, 011
// - Wait timing bit flags the boundary gap one clock earlier
// - Edge bit picks falling or rising edge
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
module frb_read_path
	import frb_pkg::*;
#(
	parameter int ADDR_W = 23,
	parameter int BANK_W = 4,
	parameter int PAGE_LONG_CYC = 2
)
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Flash bus pins from the host
	input wire logic chip_en_n,
	input wire logic latch_en_n,
	input wire logic out_en_n,
	input wire logic bus_clk,
	input wire logic [ADDR_W-1:0] addr,
	// Device answer
	output logic [15:0] data_out,
	output logic data_oe,
	output logic wait_o,
	output logic wait_oe,
	output logic standby,
	// Array and other read sources
	output logic [ADDR_W-1:0] array_addr,
	input wire logic [15:0] array_data,
	input wire logic [15:0] status_data,
	input wire logic [15:0] query_data,
	input wire logic [15:0] sig_data
);
	logic [15:0] cfg;
	frb_src_t src;
	logic [BANK_W-1:0] prog_bank;
	logic prog_busy;
	logic aw_hold, w_hold;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [1:0] ce_s, le_s, oe_s, clk_s;
	logic [ADDR_W-1:0] a_s1, a_s2, a_d;
	logic ce_n, le_n, oe_n, kq, kq_d, le_d, ce_d, oe_d;
	logic edge_act, start_req, armed;
	logic async_mode;
	logic [2:0] lat_code, len_code;
	logic wrap_on, hold2, wait_hi, wait_early;
	logic burst_on, in_lat, done;
	logic [2:0] lat_cnt;
	logic [1:0] ins_cnt;
	logic ins_used, hold_ph;
	logic [4:0] words;
	logic [ADDR_W-1:0] cur, base;
	logic [ADDR_W-3:0] page;
	logic [$clog2(PAGE_LONG_CYC+1)-1:0] page_cnt;
	logic [$clog2(STANDBY_CYC+1)-1:0] idle_cnt;
	logic [4:0] blk_mask, words_max;
	logic data_valid, wait_ahead, wait_act;
	logic [15:0] src_word;
	logic [ADDR_W-1:0] next_cur;

	assign async_mode = cfg[READ_SELECT_POS];
	assign lat_code = cfg[LATENCY_LSB +: 3];
	assign wait_hi = cfg[WAIT_POLARITY_POS];
	assign hold2 = cfg[DATA_HOLD_POS];
	assign wait_early = cfg[WAIT_TIMING_POS];
	assign len_code = cfg[LENGTH_LSB +: 3];
	assign wrap_on = ~cfg[WRAP_SELECT_POS] && len_code != LEN_CONT;

	// AXI4-Lite write channel; address and data taken in either order
	assign s_axi_awready = ~aw_hold && ~s_axi_bvalid;
	assign s_axi_wready = ~w_hold && ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_hold && w_hold)
			begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == CFG_OFS || aw_addr == MODE_OFS ||
					aw_addr == PROG_OFS) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Configuration, read source and program bank registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cfg <= CFG_RESET;
			src <= frb_src_array;
			prog_bank <= '0;
			prog_busy <= 1'b0;
		end
		else if (aw_hold && w_hold)
		begin
			if (aw_addr == CFG_OFS)
			begin
				if (w_strb[0])
					cfg[7:0] <= w_data[7:0];
				if (w_strb[1])
					cfg[15:8] <= w_data[15:8];
			end
			if (aw_addr == MODE_OFS && w_strb[0])
				src <= frb_src_t'(w_data[1:0]);
			// Single busy bank register enforces one bank in program/erase
			if (aw_addr == PROG_OFS && w_strb[0])
			begin
				prog_busy <= w_data[7];
				prog_bank <= w_data[BANK_W-1:0];
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr)
				CFG_OFS: s_axi_rdata <= {16'h0000, cfg};
				MODE_OFS: s_axi_rdata <= {30'h0000_0000, src};
				STAT_OFS: s_axi_rdata <= {27'h0000_0000, standby, burst_on,
					in_lat, done, ins_used};
				PROG_OFS: s_axi_rdata <= {24'h0000_00, prog_busy,
					{(7-BANK_W){1'b0}}, prog_bank};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Pin synchronisers; only the second stage is read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ce_s <= 2'b11;
			le_s <= 2'b11;
			oe_s <= 2'b11;
			clk_s <= 2'b00;
			a_s1 <= '0;
			a_s2 <= '0;
		end
		else
		begin
			ce_s <= {ce_s[0], chip_en_n};
			le_s <= {le_s[0], latch_en_n};
			oe_s <= {oe_s[0], out_en_n};
			clk_s <= {clk_s[0], bus_clk};
			a_s1 <= addr;
			a_s2 <= a_s1;
		end
	end
	assign ce_n = ce_s[1];
	assign le_n = le_s[1];
	assign oe_n = oe_s[1];
	assign kq = clk_s[1];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			kq_d <= 1'b0;
			le_d <= 1'b1;
			ce_d <= 1'b1;
			oe_d <= 1'b1;
			a_d <= '0;
		end
		else
		begin
			kq_d <= kq;
			le_d <= le_n;
			ce_d <= ce_n;
			oe_d <= oe_n;
			a_d <= a_s2;
		end
	end
	// A halted bus clock makes no edge, so the burst simply stands
	assign edge_act = cfg[ACTIVE_EDGE_POS] ? (kq && !kq_d) : (!kq && kq_d);
	assign start_req = (!le_n && le_d && !ce_n) || (!ce_n && ce_d && !le_n);

	// Burst helpers
	always_comb
	begin
		unique case (len_code)
			LEN_4: blk_mask = 5'h03;
			LEN_8: blk_mask = 5'h07;
			default: blk_mask = 5'h0F;
		endcase
		words_max = blk_mask;
		next_cur = cur + 1'b1;
		if (wrap_on)
			next_cur = (cur & ~ADDR_W'(blk_mask)) |
				((cur + 1'b1) & ADDR_W'(blk_mask));
	end

	// Burst engine, advanced only on active bus clock edges
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			armed <= 1'b0;
			burst_on <= 1'b0;
			in_lat <= 1'b0;
			done <= 1'b0;
			lat_cnt <= 3'h0;
			ins_cnt <= 2'h0;
			ins_used <= 1'b0;
			hold_ph <= 1'b0;
			words <= 5'h00;
			cur <= '0;
			base <= '0;
		end
		else if (async_mode || ce_n)
		begin
			armed <= 1'b0;
			burst_on <= 1'b0;
			in_lat <= 1'b0;
			done <= 1'b0;
		end
		else if (start_req)
			armed <= 1'b1;
		else if (armed && edge_act)
		begin
			armed <= 1'b0;
			burst_on <= 1'b1;
			in_lat <= 1'b1;
			done <= 1'b0;
			lat_cnt <= (lat_code < LAT_2 || lat_code > LAT_5) ? LAT_5 :
				lat_code;
			ins_cnt <= 2'h0;
			ins_used <= 1'b0;
			hold_ph <= 1'b0;
			words <= 5'h00;
			cur <= a_s2;
			base <= a_s2;
		end
		else if (burst_on && edge_act)
		begin
			// Suspend is just missing edges, so all state is retained
			if (in_lat)
			begin
				if (lat_cnt <= 3'h1)
					in_lat <= 1'b0;
				lat_cnt <= lat_cnt - 3'h1;
			end
			else if (ins_cnt != 2'h0)
				ins_cnt <= ins_cnt - 2'h1;
			else if (hold2 && !hold_ph)
				hold_ph <= 1'b1;
			else if (!done)
			begin
				hold_ph <= 1'b0;
				if (src == frb_src_array)
				begin
					cur <= next_cur;
					words <= words + 5'h01;
					if (len_code != LEN_CONT && words == words_max)
						done <= 1'b1;
					// Misaligned unwrapped start pays once at 16-word edge
					if (!wrap_on && !ins_used && cur[3:0] == 4'hF &&
						base[1:0] != 2'h0)
					begin
						ins_cnt <= base[1:0];
						ins_used <= 1'b1;
					end
				end
			end
		end
	end

	assign data_valid = burst_on && !in_lat && ins_cnt == 2'h0 && !done;
	// Early timing flags the gap one active edge before it opens
	assign wait_ahead = burst_on && !in_lat && ins_cnt == 2'h0 && !done &&
		(!hold2 || hold_ph) && src == frb_src_array && !wrap_on &&
		!ins_used && cur[3:0] == 4'hF && base[1:0] != 2'h0;
	assign wait_act = async_mode ? 1'b0 :
		(burst_on && (!data_valid || (wait_early && wait_ahead)));

	// Asynchronous page tracking and automatic standby
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			page <= '0;
			page_cnt <= '0;
			idle_cnt <= '0;
			standby <= 1'b0;
		end
		else
		begin
			if (a_s2[ADDR_W-1:2] != page || ce_n)
			begin
				page <= a_s2[ADDR_W-1:2];
				page_cnt <= '0;
			end
			else if (page_cnt != PAGE_LONG_CYC[$bits(page_cnt)-1:0])
				page_cnt <= page_cnt + 1'b1;
			// Activity is seen on settled copies only, never a first stage
			if (!async_mode || a_s2 != a_d || le_n != le_d || ce_n != ce_d ||
				oe_n != oe_d)
			begin
				idle_cnt <= '0;
				standby <= 1'b0;
			end
			else if (idle_cnt != STANDBY_CYC[$bits(idle_cnt)-1:0])
				idle_cnt <= idle_cnt + 1'b1;
			else
				standby <= 1'b1;
		end
	end

	always_comb
	begin
		unique case (src)
			frb_src_array: src_word = array_data;
			frb_src_status: src_word = status_data;
			frb_src_query: src_word = query_data;
			frb_src_sig: src_word = sig_data;
		endcase
	end
	// Single synchronous reads never advance, so the word repeats
	assign array_addr = async_mode ? a_s2 : cur;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			data_out <= 16'h0000;
			data_oe <= 1'b0;
			wait_o <= 1'b0;
			wait_oe <= 1'b0;
		end
		else
		begin
			data_oe <= !ce_n && !oe_n;
			if (async_mode)
			begin
				if (page_cnt == PAGE_LONG_CYC[$bits(page_cnt)-1:0] ||
					src != frb_src_array)
					data_out <= src_word;
			end
			else if (data_valid)
				data_out <= src_word;
			wait_o <= wait_act ~^ wait_hi;
			wait_oe <= !ce_n && !oe_n;
		end
	end
endmodule // frb_read_path

/* File: verif/frb_host_model.sv */
// Host side of the flash bus: clock runs only inside frames
module frb_host_model
(
	// Clock
	input wire logic aclk,
	// Bench control
	input wire logic run,
	input wire logic pause,
	input wire logic rise,
	input wire logic oe_n,
	// Flash side
	output logic bus_clk,
	output logic out_en_n,
	output logic smp
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt = 3'h0;
	initial bus_clk = 1'b0;
	initial out_en_n = 1'b1;
	initial smp = 1'b0;
	// Halting leaves the clock at whatever level it had
	always @(posedge aclk)
	begin
		out_en_n <= oe_n || pause;
		smp <= 1'b0;
		if (!run)
		begin
			bus_clk <= !rise;
			cnt <= 3'h0;
		end
		else if (!pause)
		begin
			cnt <= cnt + 3'h1;
			if (cnt == 3'h7)
			begin
				bus_clk <= !bus_clk;
				smp <= (bus_clk == rise);
			end
		end
	end
endmodule // frb_host_model

/* File: verif/frb_read_path_properties.sv */
// Port checker for the flash read path, bound to the design top
module frb_checker
	import frb_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axi_awready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Flash pins
	input wire logic chip_en_n,
	input wire logic out_en_n,
	input wire logic data_oe,
	input wire logic wait_oe
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Five cycles cover the input synchronisers and the output flop
	a_wait_float: assert property ((chip_en_n || out_en_n)[*5] |-> !wait_oe)
		else $error("wait output still driven");
	a_drive_on: assert property ((!chip_en_n && !out_en_n)[*5] |-> data_oe)
		else $error("data not driven while selected");
	a_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("address taken during response");
	a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr > PROG_OFS
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_reset_quiet: assert property ($rose(aresetn) |-> !data_oe && !wait_oe
		&& !s_axi_rvalid && !s_axi_bvalid)
		else $error("outputs active after reset");
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_wait: cover property (wait_oe);
endmodule // frb_checker

bind frb_read_path frb_checker u_chk (.aclk, .aresetn, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .s_axi_awready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .chip_en_n, .out_en_n, .data_oe,
	.wait_oe);

/* File: verif/test_frb_read_path.sv */
// Self-checking bench for the flash read path
module test_frb_read_path
	import frb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, g;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic chip_en_n = 1'b1, latch_en_n = 1'b1, oe_n = 1'b1;
	logic run = 1'b0, pause = 1'b0, rise = 1'b1;
	logic out_en_n, bus_clk, smp, data_oe, wait_o, wait_oe, standby;
	logic [22:0] addr = '0, array_addr;
	logic [15:0] data_out, array_data;
	int n_errors = 0, checks = 0, seed = 14, a, s;
	assign array_data = ~array_addr[15:0];
	always #25 aclk = ~aclk;
	frb_host_model hm (.aclk, .run, .pause, .rise, .oe_n, .bus_clk,
		.out_en_n, .smp);
	frb_read_path uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_en_n,
		.latch_en_n, .out_en_n, .bus_clk, .addr, .data_out, .data_oe,
		.wait_o, .wait_oe, .standby, .array_addr, .array_data,
		.status_data(16'h5A01), .query_data(16'h5A02),
		.sig_data(16'h5A03));
	task automatic chk(input logic [31:0] v, input logic [31:0] e);
		checks++;
		if (v !== e)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got %h exp %h", $time, v, e);
		end
	endtask
	task automatic end_of_test;
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic axw(input logic [7:0] ad, input logic [31:0] d);
		logic aw, w, b;
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(negedge aclk);
			aw = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (aw)
				s_axi_awvalid <= 1'b0;
			if (w)
				s_axi_wvalid <= 1'b0;
		end while (!b);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic axr(input logic [7:0] ad);
		logic ar, v;
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ar = s_axi_arready;
			v = s_axi_rvalid;
			g = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ar)
				s_axi_arvalid <= 1'b0;
		end while (!v);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	// Burst against a queue model; -1 marks a wait sample
	task automatic burst(input int st, len, wrp, lat, pol, hold, edg, sp,
		src);
		int q[$];
		int n, ad, i, lw, e, sq;
		n = (len == 7) ? 20 : 4 << (len - 1);
		sq = (len == 7 || !wrp);
		for (i = 0; i < n; i++)
		begin
			ad = sq ? st + i : (st & ~(n - 1)) + (st + i) % n;
			if (sq && ad == (st | 15) + 1)
				repeat (st % 4) q.push_back(-1);
			e = src ? 16'h5A00 | src : ~ad & 16'hFFFF;
			repeat (hold + 1) q.push_back(e);
		end
		axw(CFG_OFS, lat << LATENCY_LSB | pol << WAIT_POLARITY_POS
			| hold << DATA_HOLD_POS | 32'h0000_0080 | edg << ACTIVE_EDGE_POS
			| (1 - wrp) << WRAP_SELECT_POS | len);
		axw(MODE_OFS, src);
		rise <= edg[0];
		chip_en_n <= 1'b0;
		latch_en_n <= 1'b0;
		oe_n <= 1'b0;
		addr <= st[22:0];
		repeat (6) @(posedge aclk);
		latch_en_n <= 1'b1;
		run <= 1'b1;
		i = 0;
		lw = 0;
		while (i < q.size() + (len != 7))
		begin
			@(posedge aclk);
			if (smp && i == 0 && wait_o === pol[0])
				lw++;
			else if (smp)
			begin
				e = (i < q.size()) ? q[i] : -1;
				if (e < 0)
					chk(wait_o, pol);
				else
					chk({wait_o, data_out}, {!pol[0], e[15:0]});
				i++;
				if (sp && i == 3)
				begin
					pause <= 1'b1;
					repeat (12) @(posedge aclk);
					chk(wait_oe, 0);
					pause <= 1'b0;
				end
			end
		end
		chk(lw >= lat - 1 && lw <= lat + 1, 1);
		run <= 1'b0;
		chip_en_n <= 1'b1;
		oe_n <= 1'b1;
		repeat (8) @(posedge aclk);
	endtask
	initial
	begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		end_of_test();
	end
	initial
	begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axr(CFG_OFS);
		chk(g, {16'h0000, CFG_RESET});
		axr(8'h40);
		chk({g[29:0], r}, {30'h0, RESP_SLVERR});
		axw(STAT_OFS, 32'h0000_001F);
		chk(r, RESP_SLVERR);
		axw(PROG_OFS, 32'h0000_0085);
		axr(PROG_OFS);
		chk(g, 32'h0000_0085);
		for (s = 0; s < 4; s++)
		begin
			axw(MODE_OFS, s);
			a = $random(seed);
			chip_en_n <= 1'b0;
			oe_n <= 1'b0;
			addr <= a[22:0];
			repeat (12) @(posedge aclk);
			chk(data_out, s ? 16'h5A00 | s : {16'h0000, ~a[15:0]});
			chk({wait_o, standby, data_oe}, 3'h3);
			addr[1:0] <= a[1:0] + 2'h1;
			repeat (8) @(posedge aclk);
			if (s == 0)
				chk(data_out, {16'h0000, ~{a[15:2], a[1:0] + 2'h1}});
		end
		chip_en_n <= 1'b1;
		oe_n <= 1'b1;
		burst(7, LEN_4, 1, 2, 1, 0, 1, 0, 0);
		burst(13, LEN_4, 0, 3, 1, 0, 0, 1, 0);
		burst(2, LEN_CONT, 1, 4, 0, 0, 1, 1, 0);
		burst(12, LEN_16, 0, 5, 1, 1, 1, 0, 0);
		burst(0, LEN_8, 1, 2, 1, 0, 1, 0, 0);
		burst($random(seed) & 15, LEN_CONT, 0, 3, 1, 0, 1, 0, 0);
		burst(0, LEN_CONT, 0, 3, 1, 0, 1, 0, 2);
		end_of_test();
	end
endmodule // test_frb_read_path
